// file: verilog/aab_pkg.sv
// package of constants and types for the async-acknowledge bus master
package aab_pkg;

  // =====================================================
  // transfer size encodings
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_LINE = 2'h3;

  // =====================================================
  // port widths
  localparam logic [1:0] PORT_8  = 2'h1;
  localparam logic [1:0] PORT_16 = 2'h2;
  localparam logic [1:0] PORT_32 = 2'h0;

  // =====================================================
  // bus geometry and limits
  localparam int ADDR_W     = 28;
  localparam int DATA_W     = 32;
  localparam int MAX_BEATS  = 16;
  localparam int FIFO_DEPTH = 32;

  // =====================================================
  // timing: one clock of 20 ns at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_MHZ       = 50;

  // =====================================================
  // reset values of the beat counter and the transfer kind pin driver
  localparam logic [3:0]  BEATS_RESET = 4'h0;
  localparam logic [1:0]  KIND_RESET  = 2'h0;

  // =====================================================
  // bus master states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_WAIT  = 2'b10,
    ST_DONE  = 2'b11
  } aab_state_t;

endpackage : aab_pkg

// file: verilog/aab_fifo.sv
// small synchronous fifo holding read beats for the requester
`timescale 1ns/1ps
`default_nettype none
module aab_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  // =====================================================
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  wire              doWrite = inValid && inReady;
  wire              doRead  = outValid && outReady;
  wire [AW-1:0]     headNext = doRead ? rdPtr + 1'b1 : rdPtr;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);

  // write port, no reset needed on the array
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointer and occupancy bookkeeping
  always_ff @(posedge clock) begin
    if (srst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) wrPtr <= wrPtr + 1'b1;
      if (doRead)  rdPtr <= rdPtr + 1'b1;
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end

  // read data comes from a register; a word written into the head slot bypasses
  // the array so outData is never stale in the cycle outValid rises
  always_ff @(posedge clock) begin
    if (srst) begin
      outData <= '0;
    end else if (doWrite && wrPtr == headNext) begin
      outData <= inData;
    end else begin
      outData <= mem[headNext];
    end
  end

endmodule : aab_fifo
`default_nettype wire

// file: verilog/aab_master.sv
// bus master sequencing single and burst transfers ended by async acknowledge
//
// What this block does
// - first clock drives address, attributes, start strobe
// - size codes: long 0, byte 1, line 3
// - size code for word is 2
// - mode: code/data first, user/super second
// - write data driven clock two until acknowledged
// - acknowledge synchronised, ready by third clock
// - complete beat on internal ack, else wait
// - burst when enabled and operand exceeds port
// - burst ends on sync or async acknowledge
// - burst holds two to sixteen beats
// - sixteen-bit port reads take upper data lines
// - sixteen-bit longword steps address, ends after two
// - thirty-two-bit line write steps address bits three, two
// - later line beats sample ack each clock
// - data bus released after final write beat
// - error acknowledge during synchronising ends with error
// - async acknowledge honoured except for dram
`timescale 1ns/1ps
`default_nettype none
module aab_master
  import aab_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          srst,
  // request from the core
  input  wire logic          reqValid,
  output logic               reqReady,
  input  wire logic [AW-1:0] reqAddr,
  input  wire logic          reqRead,
  input  wire logic [1:0]    reqSize,
  input  wire logic [1:0]    reqPortSize,
  input  wire logic          reqBurstEn,
  input  wire logic          reqDram,
  input  wire logic          reqCode,
  input  wire logic          reqSuper,
  input  wire logic [1:0]    reqKind,
  // write data, one word per beat
  input  wire logic          wrValid,
  output logic               wrReady,
  input  wire logic [DW-1:0] wrData,
  // read data and completion
  output logic               rdValid,
  input  wire logic          rdReady,
  output logic      [DW-1:0] rdData,
  output logic               doneErr,
  output logic               donePulse,
  // bus pins
  output logic      [AW-1:0] addr,
  output logic      [1:0]    transferKind,
  output logic               readNotWrite,
  output logic      [1:0]    xferSize,
  output logic               accessModeAttr,
  output logic               transferStart_n,
  input  wire logic          asyncAck_n,
  input  wire logic          syncAck_n,
  input  wire logic          errorAck_n,
  input  wire logic [DW-1:0] dataIn,
  output logic      [DW-1:0] dataOut,
  output logic               dataOe
);

  // =====================================================
  // state
  aab_state_t  state;
  aab_state_t  next_state;
  logic [3:0]  beatsLeft;
  logic        isRead;
  logic        isBurst;
  logic        noAsync;
  logic        isCode;
  logic        isSuper;
  logic        port32;
  logic        port16;
  logic        ackSync1;
  logic        ackSync2;
  logic        errSeen;
  logic        fifoReady;

  // =====================================================
  // decode of the incoming request
  wire         burstWanted;
  wire  [3:0]  beatsMinus1;
  wire  [1:0]  beatSizeReq;
  wire  [3:0]  nextLow;
  wire         internalAck;
  wire         beatEnd;
  wire         lastBeat;
  wire         startReq;

  // operand larger than port and burst enabled selects burst mode
  assign burstWanted = reqBurstEn && (reqSize != SIZE_BYTE) &&
         !(reqPortSize == PORT_32 && reqSize != SIZE_LINE) &&
         !(reqPortSize == PORT_16 && reqSize == SIZE_WORD);
  // beat count per operand and port; bursts give 2 to 16 beats
  assign beatsMinus1 = !burstWanted ? 4'h0 :
         (reqSize == SIZE_LINE) ?
           ((reqPortSize == PORT_32) ? 4'h3 : (reqPortSize == PORT_16) ? 4'h7 : 4'hf) :
         (reqSize == SIZE_LONG) ? ((reqPortSize == PORT_16) ? 4'h1 : 4'h3) :
         4'h1;
  // burst size shows the operand, otherwise the request itself
  assign beatSizeReq = reqSize;
  // next low address bits per beat: the latched port width picks the bits that step,
  // so a core changing its port input mid-burst cannot disturb the sequence
  assign nextLow = port16 ? {addr[3:1] + 3'h1, addr[0]} :
                   port32 ? {addr[3:2] + 2'h1, addr[1:0]} :
                   addr[3:0] + 4'h1;

  // async ack honoured off dram, sync ack in bursts and singles too
  assign internalAck = (ackSync2 && !noAsync) || !syncAck_n;
  assign beatEnd = (state == ST_WAIT) && (internalAck || errSeen);
  assign lastBeat = (beatsLeft == 4'h0) || errSeen;
  // reads wait for fifo room; a long burst can still overrun a nearly full fifo
  assign startReq = (state == ST_IDLE) && reqValid &&
         (reqRead ? fifoReady : wrValid);

  assign reqReady = (state == ST_IDLE) && (reqRead ? fifoReady : wrValid);
  // first write word pulled at start, each next one only when a beat completes mid-burst
  assign wrReady = startReq || (beatEnd && !isRead && !lastBeat);

  // =====================================================
  // acknowledge synchroniser: second stage feeds the sampler
  always_ff @(posedge clock) begin
    if (srst) begin
      ackSync1 <= 1'b0;
      ackSync2 <= 1'b0;
    end else begin
      ackSync1 <= !asyncAck_n && (state != ST_IDLE);
      ackSync2 <= ackSync1 && (state != ST_IDLE);
    end
  end

  // error acknowledge seen while the ack is still in the synchroniser
  always_ff @(posedge clock) begin
    if (srst || state == ST_IDLE) begin
      errSeen <= 1'b0;
    end else if (!errorAck_n) begin
      errSeen <= 1'b1;
    end
  end

  // =====================================================
  // state sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (startReq) next_state = ST_START;
      ST_START: next_state = ST_WAIT;
      ST_WAIT:  if (beatEnd) begin
        next_state = lastBeat ? ST_DONE : ST_WAIT;
      end
      ST_DONE:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) state <= ST_IDLE;
    else      state <= next_state;
  end

  // transfer attributes latched at start
  always_ff @(posedge clock) begin
    if (srst) begin
      addr         <= '0;
      transferKind <= KIND_RESET;
      readNotWrite <= 1'b1;
      xferSize     <= SIZE_LONG;
      beatsLeft    <= BEATS_RESET;
      isRead       <= 1'b1;
      isBurst      <= 1'b0;
      noAsync      <= 1'b0;
      isCode       <= 1'b0;
      isSuper      <= 1'b0;
      port16       <= 1'b0;
      port32       <= 1'b0;
    end else if (startReq) begin
      addr         <= reqAddr;
      transferKind <= reqKind;
      readNotWrite <= reqRead;
      xferSize     <= beatSizeReq;
      beatsLeft    <= beatsMinus1;
      isRead       <= reqRead;
      isBurst      <= burstWanted;
      noAsync      <= reqDram;
      isCode       <= reqCode;
      isSuper      <= reqSuper;
      port16       <= (reqPortSize == PORT_16);
      port32       <= (reqPortSize == PORT_32);
    end else if (beatEnd && !lastBeat) begin
      beatsLeft <= beatsLeft - 4'h1;
      addr[3:0] <= nextLow;
    end
  end

  // strobe and access mode: code/data in first clock, privilege after
  always_ff @(posedge clock) begin
    if (srst) begin
      transferStart_n <= 1'b1;
      accessModeAttr  <= 1'b0;
    end else begin
      transferStart_n <= !startReq;
      accessModeAttr  <= startReq ? reqCode : isSuper;
    end
  end

  // write data driven from second clock until final acknowledge
  always_ff @(posedge clock) begin
    if (srst) begin
      dataOut <= '0;
      dataOe  <= 1'b0;
    end else begin
      if (wrValid && wrReady) dataOut <= wrData;
      dataOe <= (state == ST_START && !isRead) ||
                (state == ST_WAIT && !isRead && !(beatEnd && lastBeat));
    end
  end

  // completion pulse and error flag
  always_ff @(posedge clock) begin
    if (srst) begin
      donePulse <= 1'b0;
      doneErr   <= 1'b0;
    end else begin
      donePulse <= beatEnd && lastBeat;
      doneErr   <= beatEnd && lastBeat && errSeen;
    end
  end

  // =====================================================
  // read beats enter the fifo; sixteen-bit ports deliver on the upper lines
  aab_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock    (clock),
    .srst     (srst),
    .inValid  (beatEnd && isRead && !errSeen),
    .inReady  (fifoReady),
    .inData   (port16 ? {dataIn[31:16], 16'h0000} : dataIn),
    .outValid (rdValid),
    .outReady (rdReady),
    .outData  (rdData)
  );

  // =====================================================
  // checks
  property startOneClock;
    @(posedge clock) disable iff (srst)
      $fell(transferStart_n) |=> transferStart_n;
  endproperty
  strobe_one_clock_a: assert property (startOneClock)
    else $error("start strobe held over one clock");

  idle_bus_quiet_a: assert property (
    @(posedge clock) disable iff (srst)
      (state == ST_IDLE && $past(state) == ST_IDLE) |-> !dataOe)
    else $error("data bus driven while idle");

  sequence ackSeen;
    !asyncAck_n && !noAsync && state == ST_WAIT;
  endsequence
  ack_sync_delay_a: assert property (
    @(posedge clock) disable iff (srst)
      ackSeen ##1 (state == ST_WAIT) |=> (ackSync2 || state != ST_WAIT))
    else $error("synchronised ack not ready by third clock");

  release_after_write_a: assert property (
    @(posedge clock) disable iff (srst)
      (beatEnd && lastBeat && !isRead) |=> !dataOe)
    else $error("data bus not released after final write");

  write_data_held_a: assert property (
    @(posedge clock) disable iff (srst)
      (state == ST_WAIT && !isRead && !beatEnd) |=> dataOe)
    else $error("write data dropped before acknowledge");

  size_word_code_a: assert property (
    @(posedge clock) disable iff (srst)
      (startReq && reqSize == SIZE_WORD) |=> xferSize == 2'h2)
    else $error("word size not coded as two");

  burst_beats_a: assert property (
    @(posedge clock) disable iff (srst)
      (startReq && burstWanted) |=> beatsLeft >= 4'h1)
    else $error("burst shorter than two beats");

  error_ends_a: assert property (
    @(posedge clock) disable iff (srst)
      (state == ST_WAIT && errSeen) |=> state == ST_DONE)
    else $error("error acknowledge did not end access");

  line_step_a: assert property (
    @(posedge clock) disable iff (srst)
      (beatEnd && !lastBeat && port32) |=> addr[3:2] == $past(addr[3:2]) + 2'h1)
    else $error("line address not stepped by one longword");

  single_beat_a: assert property (
    @(posedge clock) disable iff (srst)
      (state == ST_WAIT && !isBurst) |-> beatsLeft == 4'h0)
    else $error("non-burst transfer with more than one beat");

  mode_code_a: assert property (
    @(posedge clock) disable iff (srst)
      (state == ST_START) |-> accessModeAttr == isCode)
    else $error("access mode not code or data in first clock");

endmodule : aab_master
`default_nettype wire

// file: tb/aab_slave_model.sv
// slave model answering the bus master with an asynchronous acknowledge
`timescale 1ns/1ps
`default_nettype none
module aab_slave_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // bus from the master
  input  wire logic        transferStart_n,
  input  wire logic        donePulse,
  input  wire logic [27:0] addr,
  input  wire logic [31:0] dataOut,
  // answer to the master
  input  wire logic [3:0]  waitStates,
  output logic             asyncAck_n,
  output logic      [31:0] dataIn
);
  logic [31:0] wrLog[$];
  logic [27:0] adLog[$];
  logic        active;
  int          tick;
  int          age;
  int          t;
  initial begin
    asyncAck_n = 1'b1;
    dataIn     = '0;
    active     = 1'b0;
    age        = 0;
  end
  // =========
  // pacing: one ack pulse a beat, spaced so the synchroniser sees each one once
  always @(posedge clock) begin
    if (srst || donePulse) begin
      active     <= 1'b0;
      asyncAck_n <= 1'b1;
    end else if (active || !transferStart_n) begin
      t = active ? tick - 1 : int'(waitStates);
      active     <= 1'b1;
      asyncAck_n <= (t != 0);
      tick       <= (t == 0) ? 4 + int'(waitStates) : t;
    end
  end
  // =========
  // data: valid from ack for three edges, then a changed value, never the old one
  always @(posedge clock) begin
    if (!asyncAck_n) begin
      dataIn <= {4'hA, addr};
      age    <= 1;
    end else if (age == 1) begin
      wrLog.push_back(dataOut);
      adLog.push_back(addr);
      age    <= 2;
    end else if (age == 2) begin
      dataIn <= ~dataIn;
      age    <= 0;
    end
  end
endmodule // aab_slave_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the async-acknowledge bus master
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aab_pkg::*;
  // =========
  // stimulus and observed signals
  logic        clock = 1'b0, srst = 1'b1, reqValid = 1'b0, reqRead = 1'b0;
  logic        reqBurstEn = 1'b0, reqDram = 1'b0, reqCode = 1'b0, reqSuper = 1'b0;
  logic        wrValid = 1'b0, rdReady = 1'b0, syncAck_n = 1'b1, errorAck_n = 1'b1;
  logic [27:0] reqAddr = '0;
  logic [1:0]  reqSize = '0, reqPortSize = '0, reqKind = '0;
  logic [31:0] wrData = '0;
  logic [3:0]  waitStates = '0;
  wire logic   reqReady, wrReady, rdValid, doneErr, donePulse, readNotWrite;
  wire logic   accessModeAttr, transferStart_n, asyncAck_n, dataOe;
  wire logic [31:0] rdData, dataIn, dataOut;
  wire logic [27:0] addr;
  wire logic [1:0]  transferKind, xferSize;
  int          miscompares = 0, checks = 0, errAt = -1, syncAt = -1, doneAt, strobes;
  logic        gotErr;
  logic [31:0] wq[$];
  logic [31:0] rq[$];
  always #10 clock = ~clock;
  aab_master uut (.clock(clock), .srst(srst), .reqValid(reqValid), .reqReady(reqReady),
    .reqAddr(reqAddr), .reqRead(reqRead), .reqSize(reqSize), .reqPortSize(reqPortSize),
    .reqBurstEn(reqBurstEn), .reqDram(reqDram), .reqCode(reqCode), .reqSuper(reqSuper),
    .reqKind(reqKind), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
    .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData), .doneErr(doneErr),
    .donePulse(donePulse), .addr(addr), .transferKind(transferKind),
    .readNotWrite(readNotWrite), .xferSize(xferSize), .accessModeAttr(accessModeAttr),
    .transferStart_n(transferStart_n), .asyncAck_n(asyncAck_n), .syncAck_n(syncAck_n),
    .errorAck_n(errorAck_n), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));
  aab_slave_model slave (.clock(clock), .srst(srst), .transferStart_n(transferStart_n),
    .donePulse(donePulse), .addr(addr), .dataOut(dataOut), .waitStates(waitStates),
    .asyncAck_n(asyncAck_n), .dataIn(dataIn));
  // =========
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one whole transfer; checks the first two clocks and the bus release after it
  task automatic xfer(input logic rd, input logic [1:0] sz, input logic [1:0] ps,
                      input logic be, input logic [27:0] a);
    int  cyc;
    int  wi;
    logic tk;
    logic wt;
    cyc = -1;
    wi = 0;
    strobes = 0;
    doneAt = -1;
    slave.wrLog.delete();
    slave.adLog.delete();
    @(negedge clock);
    {reqRead, reqSize, reqPortSize, reqBurstEn, reqAddr} = {rd, sz, ps, be, a};
    reqKind = reqKind + 2'h1;
    reqValid = 1'b1;
    wrValid = !rd;
    wrData = rd ? 32'h0000_0000 : wq[0];
    for (int n = 0; n < 300 && doneAt < 0; n++) begin
      @(posedge clock);
      tk = reqValid && reqReady;
      wt = wrValid && wrReady;
      @(negedge clock);
      if (tk) reqValid = 1'b0;
      if (wt) begin
        wi++;
        wrValid = (wi < wq.size());
        if (wrValid) wrData = wq[wi];
      end
      if (cyc > 0) cyc++;
      if (!transferStart_n) strobes++;
      if (!transferStart_n && cyc < 0) begin
        cyc = 1;
        chk(addr, a);
        chk(readNotWrite, rd);
        chk(xferSize, sz);
        chk(transferKind, reqKind);
        chk(accessModeAttr, reqCode);
      end
      if (cyc == 2) begin
        chk(transferStart_n, 1'b1);
        chk(accessModeAttr, reqSuper);
        chk(dataOe, !rd);
        if (!rd) chk(dataOut, wq[0]);
      end
      errorAck_n = (cyc != errAt);
      syncAck_n = !(syncAt > 0 && cyc >= syncAt);
      if (donePulse) begin
        doneAt = cyc;
        gotErr = doneErr;
      end
    end
    {syncAck_n, errorAck_n, reqValid, wrValid} = 4'b1100;
    chk(doneAt >= 0, 1'b1);
    @(negedge clock);
    chk(dataOe, 1'b0);
    chk(transferStart_n, 1'b1);
  endtask
  task automatic drain();
    rq.delete();
    rdReady = 1'b1;
    repeat (8) begin
      @(posedge clock);
      if (rdValid) rq.push_back(rdData);
    end
    @(negedge clock);
    rdReady = 1'b0;
  endtask
  // =========
  // scenarios
  task automatic t_byte_write();
    wq = '{32'h1122_3344};
    xfer(1'b0, SIZE_BYTE, PORT_32, 1'b0, 28'h000_0101);
    chk(doneAt, 5);
    chk(gotErr, 1'b0);
    chk(slave.wrLog[0], wq[0]);
    $display("test byte write done");
  endtask
  task automatic t_word_read();
    {reqCode, reqSuper, waitStates} = {2'b11, 4'h3};
    xfer(1'b1, SIZE_WORD, PORT_16, 1'b1, 28'h012_3456);
    chk(doneAt, 8);
    chk(slave.adLog.size(), 1);
    drain();
    chk(rq[0][31:16], 16'hA012);
    $display("test word read done");
  endtask
  task automatic t_long_burst();
    {reqCode, reqSuper, waitStates} = {2'b01, 4'h0};
    xfer(1'b1, SIZE_LONG, PORT_16, 1'b1, 28'h345_0200);
    chk(doneAt, 9);
    chk(strobes, 1);
    chk(slave.adLog.size(), 2);
    chk(slave.adLog[0][1:0], 2'h0);
    chk(slave.adLog[1][1:0], 2'h2);
    drain();
    chk(rq.size(), 2);
    chk(rq[0][31:16], 16'hA345);
    $display("test longword burst done");
  endtask
  task automatic t_line_write();
    {reqCode, reqSuper, waitStates} = {2'b00, 4'h1};
    wq = '{32'hA1A1_0001, 32'hB2B2_0002, 32'hC3C3_0003, 32'hD4D4_0004};
    xfer(1'b0, SIZE_LINE, PORT_32, 1'b1, 28'h000_0300);
    chk(doneAt, 21);
    chk(slave.wrLog.size(), 4);
    for (int i = 0; i < 4; i++) begin
      chk(slave.wrLog[i], wq[i]);
      chk(slave.adLog[i][3:2], i[1:0]);
    end
    $display("test line write done");
  endtask
  task automatic t_error();
    waitStates = 4'h0;
    errAt = 2;
    wq = '{32'h5555_AAAA};
    xfer(1'b0, SIZE_LONG, PORT_32, 1'b0, 28'h000_0400);
    chk(gotErr, 1'b1);
    errAt = -1;
    $display("test error done");
  endtask
  task automatic t_dram();
    reqDram = 1'b1;
    syncAt = 8;
    xfer(1'b1, SIZE_BYTE, PORT_8, 1'b0, 28'h000_0500);
    chk(doneAt >= 9, 1'b1);
    reqDram = 1'b0;
    syncAt = -1;
    drain();
    chk(rq[0], 32'hA000_0500);
    $display("test dram done");
  endtask
  // =========
  // main sequence and watchdog
  initial begin
    repeat (20) @(negedge clock);
    srst = 1'b0;
    t_byte_write();
    t_word_read();
    t_long_burst();
    t_line_write();
    t_error();
    t_dram();
    finish_test();
  end
  initial begin
    #(20 * 3000);
    miscompares++;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
